// ### shared/dcps_pkg.sv
// package for the disk controller phase sequencer
// assumes a single 250 mhz clock domain
package dcps_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [2:0] DCPS_ADDR_STATUS = 3'h4;
  localparam logic [2:0] DCPS_ADDR_DATA = 3'h5;

  // ****************************************
  // main status bit positions
  // ****************************************
  localparam int DCPS_MS_HREQ = 7;
  localparam int DCPS_MS_DIR = 6;
  localparam int DCPS_MS_PROG = 5;
  localparam int DCPS_MS_ACTIVE = 4;
  localparam int DCPS_MS_DRV_HI = 3;

  // ****************************************
  // data rates
  // ****************************************
  localparam logic [1:0] DCPS_RATE_500K = 2'h0;
  localparam logic [1:0] DCPS_RATE_300K = 2'h1;
  localparam logic [1:0] DCPS_RATE_250K = 2'h2;
  localparam logic [1:0] DCPS_RATE_1M = 2'h3;

  // ****************************************
  // timing
  // ****************************************
  localparam int DCPS_CLK_MHZ = 250;
  localparam int DCPS_POLL_US = 1000;
  localparam int DCPS_PDOWN_MS = 512;
  localparam int DCPS_POLL_CYC = DCPS_POLL_US * DCPS_CLK_MHZ;
  localparam longint DCPS_PDOWN_CYC = longint'(DCPS_PDOWN_MS) * 1000 * DCPS_CLK_MHZ;
  localparam int DCPS_POLL_LOOP_CYC = 64;
  localparam int DCPS_STEP_CYC = 250;
  localparam logic [7:0] DCPS_RESULT_STATUS_OVR = 8'h40;
  localparam logic [7:0] DCPS_RESULT_STATUS_OK = 8'h00;
  localparam logic [7:0] DCPS_RESULT_STATUS_POLL = 8'hc0;

  typedef enum {
    DCPS_IDLE, DCPS_CMD, DCPS_EXEC, DCPS_PAD, DCPS_RESULT, DCPS_POLL
  } dcps_phase_e;

endpackage

// ### rtl/dcps_sync.sv
// three-stage synchroniser with agreement filter
// assumes the input is asynchronous to clk_sys
`timescale 1ns/1ps
module dcps_sync (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // signal
  input wire logic d_in,
  output logic q_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      q_out <= 1'b0;
    end else begin
      s1_reg <= d_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // change counts once stages two and three agree
      if (s2_reg == s3_reg) begin
        q_out <= s3_reg;
      end
    end
  end
endmodule

// ### rtl/dcps_timer.sv
// reloadable down counter raising a one-cycle done pulse
// assumes load and run come from the same clock domain
`timescale 1ns/1ps
module dcps_timer #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // control
  input wire logic load,
  input wire logic [WIDTH-1:0] count,
  input wire logic run,
  // status
  output logic done
);
  logic [WIDTH-1:0] cnt_reg;

  if (WIDTH < 2) begin : g_width_bad
    $error("timer width too small");
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= '0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        cnt_reg <= count;
      end else if (run && cnt_reg != '0) begin
        cnt_reg <= cnt_reg - 1'b1;
        done <= (cnt_reg == WIDTH'(1));
      end
    end
  end
endmodule

// ### rtl/dcps_top.sv
// phase sequencer of the disk controller: idle, command, execution,
// result and drive polling phases, status register and byte handshake
// assumes host strobes and dma acknowledge are asynchronous pins;
// command decode and the disk side are outside, driving the cmd_* and disk_* inputs
//
// Functional notes
// - late host service ends execution, flags overrun or underrun, goes to result
// - write underrun pads sector with last good byte, then ends execution
// - interrupt at execution end, cleared by reading first result byte
// - dma acknowledge alone counts as one byte; host pulses it per byte
// - non-dma fifo off: interrupt per byte, request and programmed bits set
// - data transfer needs valid address plus active read or write strobe
// - non-dma late byte: finish sector, terminate, report overrun
// - after last non-dma byte interrupt, request and direction set, programmed cleared
// - fifo on: interrupt on threshold; each byte drops it for one cycle with burst, two without
// - status always readable; read stays in execution until fifo drained
// - request status bit mirrors the interrupt level in non-dma execution
// - result bytes in fixed order per command; host reads all first
// - final result byte read clears command active and readies next command
// - polling loop then idle after reset: request set, direction clear; opcode starts command
// - idle enters drive polling every 1 ms at 500 kbps over four drives
// - ready lines toggle only after reset, interrupt for drive 0, four queries clear
// - stepping happens in polling phase even with polling disabled
// - power down waits 512 ms at 500 kbps and 1 mbps after motor-off time when enabled
// - command during polling withholds next byte ready until the loop ends
// - result bytes only via data register offset, only in result phase
// - first command byte sets command active; no result phase clears it; one-byte commands without result set it only when written during polling
`timescale 1ns/1ps
module dcps_top
  import dcps_pkg::*;
#(
  parameter int POLL_CYC = dcps_pkg::DCPS_POLL_CYC,
  parameter longint PDOWN_CYC = dcps_pkg::DCPS_PDOWN_CYC,
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // host bus pins
  input wire logic [2:0] addr,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic dack_n,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic irq,
  output logic drq,
  // configuration
  input wire logic dma_mode,
  input wire logic fifo_on,
  input wire logic burst_on,
  input wire logic [3:0] fifo_thresh,
  input wire logic [1:0] data_rate,
  input wire logic poll_disable,
  input wire logic autopd_en,
  input wire logic motor_off_expired,
  // command decode
  input wire logic cmd_last_byte,
  input wire logic cmd_has_result,
  input wire logic cmd_is_read,
  input wire logic [2:0] result_count,
  input wire logic [3:0] step_needed,
  input wire logic [3:0] step_dir_want,
  // disk side
  input wire logic disk_byte_ready,
  input wire logic disk_sector_end,
  input wire logic disk_exec_done,
  input wire logic disk_service_late,
  input wire logic [7:0] disk_rbyte,
  output logic [7:0] disk_wbyte,
  output logic disk_wstb,
  output logic step_pulse,
  output logic step_dir,
  output logic power_down
);
  import dcps_pkg::*;

  if (FIFO_DEPTH != 16) begin : g_depth_bad
    $error("fifo depth must be 16");
  end

  // ****************************************
  // pin synchronisers and strobes
  // ****************************************
  logic rd_s;
  logic wr_s;
  logic dack_s;
  logic rd_d_reg;
  logic wr_d_reg;
  logic dack_d_reg;
  dcps_sync u_rd (.clk_sys(clk_sys), .nrst(nrst), .d_in(~rd_n), .q_out(rd_s));
  dcps_sync u_wr (.clk_sys(clk_sys), .nrst(nrst), .d_in(~wr_n), .q_out(wr_s));
  dcps_sync u_dk (.clk_sys(clk_sys), .nrst(nrst), .d_in(~dack_n), .q_out(dack_s));

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rd_d_reg <= 1'b0;
      wr_d_reg <= 1'b0;
      dack_d_reg <= 1'b0;
    end else begin
      rd_d_reg <= rd_s;
      wr_d_reg <= wr_s;
      dack_d_reg <= dack_s;
    end
  end

  // address qualifies only with a strobe; dack replaces the address
  logic rd_edge;
  logic wr_edge;
  logic dack_edge;
  logic data_rd;
  logic data_wr;
  logic dma_xfer;
  assign rd_edge = rd_s & ~rd_d_reg;
  assign wr_edge = wr_s & ~wr_d_reg;
  assign dack_edge = dack_s & ~dack_d_reg;
  assign data_rd = rd_edge & ~dack_s & (addr == DCPS_ADDR_DATA);
  assign data_wr = wr_edge & ~dack_s & (addr == DCPS_ADDR_DATA);
  // acknowledge edge counts as a byte, strobe or not
  assign dma_xfer = dack_edge & dma_mode;

  // ****************************************
  // phase state and data fifo
  // ****************************************
  dcps_phase_e phase_reg;
  logic [7:0] fifo_mem [FIFO_DEPTH];
  logic [4:0] fcnt_reg;
  logic [3:0] fhead_reg;
  logic [7:0] last_good_reg;
  logic ovr_reg;
  logic active_reg;
  logic [2:0] res_left_reg;
  logic [1:0] res_idx_reg;
  logic sector_done_reg;
  logic poll_hold_reg;
  logic loop_done;
  logic [3:0] ready_chg_reg;
  logic host_xfer;
  logic fifo_trig;
  logic irq_next;
  logic poll_tick;
  logic phase_next_is_result;
  logic phase_next_is_idle_done;

  assign host_xfer = data_rd | data_wr | dma_xfer;

  function automatic logic [4:0] depth_minus(input logic [3:0] t);
    depth_minus = 5'(FIFO_DEPTH) - {1'b0, t};
  endfunction

  // threshold trigger shared by dma and interrupt modes
  always_comb begin
    if (!fifo_on) begin
      fifo_trig = cmd_is_read ? (fcnt_reg != 5'h0) : (fcnt_reg == 5'h0);
    end else if (cmd_is_read) begin
      fifo_trig = (fcnt_reg >= depth_minus(fifo_thresh)) ||
        (sector_done_reg && fcnt_reg != 5'h0);
    end else begin
      fifo_trig = (fcnt_reg <= {1'b0, fifo_thresh}) && !sector_done_reg;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      phase_reg <= DCPS_POLL;
      active_reg <= 1'b0;
      ovr_reg <= 1'b0;
      res_left_reg <= 3'h0;
      res_idx_reg <= 2'h0;
      sector_done_reg <= 1'b0;
      poll_hold_reg <= 1'b0;
    end else begin
      case (phase_reg)
        DCPS_IDLE: begin
          // opcode byte starts the command phase
          if (data_wr) begin
            active_reg <= cmd_has_result || !cmd_last_byte;
            phase_reg <= cmd_last_byte ? DCPS_EXEC : DCPS_CMD;
          end else if (poll_tick) begin
            phase_reg <= DCPS_POLL;
          end
        end
        DCPS_CMD: begin
          if (data_wr && cmd_last_byte) begin
            active_reg <= cmd_has_result;
            phase_reg <= DCPS_EXEC;
          end
        end
        DCPS_EXEC: begin
          if (disk_sector_end) begin
            sector_done_reg <= 1'b1;
          end
          if (disk_service_late) begin
            ovr_reg <= 1'b1;
          end
          // writes pad on underrun; reads end only once the fifo is drained
          if (!cmd_is_read && (disk_service_late || ovr_reg) && fcnt_reg == 5'h0) begin
            phase_reg <= DCPS_PAD;
          end else if ((disk_exec_done || (ovr_reg && sector_done_reg)) &&
                       fcnt_reg == 5'h0) begin
            // no result phase clears the active flag right away
            active_reg <= cmd_has_result;
            res_left_reg <= result_count;
            res_idx_reg <= 2'h0;
            phase_reg <= cmd_has_result ? DCPS_RESULT : DCPS_IDLE;
          end
        end
        DCPS_PAD: begin
          if (disk_sector_end) begin
            res_left_reg <= result_count;
            res_idx_reg <= 2'h0;
            phase_reg <= DCPS_RESULT;
          end
        end
        DCPS_RESULT: begin
          // last result byte read frees the command path
          if (data_rd) begin
            res_left_reg <= res_left_reg - 3'h1;
            res_idx_reg <= res_idx_reg + 2'h1;
            if (res_left_reg <= 3'h1) begin
              active_reg <= 1'b0;
              ovr_reg <= 1'b0;
              sector_done_reg <= 1'b0;
              phase_reg <= DCPS_IDLE;
            end
          end
        end
        DCPS_POLL: begin
          // a command byte here holds the next-byte ready until loop end
          if (data_wr) begin
            active_reg <= 1'b1;
            poll_hold_reg <= 1'b1;
          end
          if (loop_done) begin
            poll_hold_reg <= 1'b0;
            phase_reg <= (active_reg || data_wr) ? DCPS_CMD : DCPS_IDLE;
          end
        end
        default: phase_reg <= DCPS_IDLE;
      endcase
    end
  end

  // fifo fill by disk side or host, drain by the other
  always_ff @(posedge clk_sys) begin
    if (phase_reg == DCPS_EXEC && cmd_is_read && disk_byte_ready &&
        fcnt_reg != 5'(FIFO_DEPTH)) begin
      fifo_mem[4'(fhead_reg + fcnt_reg[3:0])] <= disk_rbyte;
    end else if (phase_reg == DCPS_EXEC && !cmd_is_read && (data_wr || dma_xfer)) begin
      fifo_mem[4'(fhead_reg + fcnt_reg[3:0])] <= wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      fcnt_reg <= 5'h0;
      fhead_reg <= 4'h0;
      last_good_reg <= 8'h00;
      disk_wbyte <= 8'h00;
      disk_wstb <= 1'b0;
    end else begin
      disk_wstb <= 1'b0;
      if (phase_reg == DCPS_EXEC && cmd_is_read) begin
        if (disk_byte_ready && fcnt_reg != 5'(FIFO_DEPTH) && !host_xfer) begin
          fcnt_reg <= fcnt_reg + 5'h1;
        end else if (host_xfer && fcnt_reg != 5'h0 && !disk_byte_ready) begin
          fcnt_reg <= fcnt_reg - 5'h1;
          fhead_reg <= fhead_reg + 4'h1;
        end
      end else if (phase_reg == DCPS_EXEC) begin
        if ((data_wr || dma_xfer) && fcnt_reg != 5'(FIFO_DEPTH)) begin
          fcnt_reg <= fcnt_reg + 5'h1;
          last_good_reg <= wdata;
        end else if (disk_byte_ready && fcnt_reg != 5'h0) begin
          fcnt_reg <= fcnt_reg - 5'h1;
          fhead_reg <= fhead_reg + 4'h1;
          disk_wbyte <= fifo_mem[fhead_reg];
          disk_wstb <= 1'b1;
        end
      end else if (phase_reg == DCPS_PAD && disk_byte_ready) begin
        disk_wbyte <= last_good_reg;
        disk_wstb <= 1'b1;
      end else begin
        fcnt_reg <= 5'h0;
      end
    end
  end

  // ****************************************
  // interrupt and dma request
  // ****************************************
  logic burst_gap_reg;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      burst_gap_reg <= 1'b0;
    end else begin
      burst_gap_reg <= host_xfer & ~burst_on & fifo_on;
    end
  end

  always_comb begin
    irq_next = irq;
    // execution end must win, else an empty read fifo would hide it
    if ((phase_reg == DCPS_EXEC || phase_reg == DCPS_PAD) &&
        (phase_next_is_result || phase_next_is_idle_done)) begin
      irq_next = 1'b1;
    end else if (phase_reg == DCPS_EXEC && !dma_mode) begin
      // per-byte request; no burst drops it for a cycle
      irq_next = fifo_trig && !host_xfer && !burst_gap_reg && !(ovr_reg && !cmd_is_read);
    end else if (phase_reg == DCPS_RESULT && data_rd && res_idx_reg == 2'h0) begin
      irq_next = 1'b0;
    end else if (phase_reg == DCPS_POLL && ready_chg_reg[0] && !poll_disable) begin
      irq_next = 1'b1;
    end else if (phase_reg == DCPS_EXEC) begin
      irq_next = 1'b0;
    end
  end

  assign phase_next_is_result = (phase_reg == DCPS_PAD && disk_sector_end) ||
    (phase_reg == DCPS_EXEC && fcnt_reg == 5'h0 && cmd_has_result &&
     (disk_exec_done || (ovr_reg && sector_done_reg)));
  assign phase_next_is_idle_done = phase_reg == DCPS_EXEC && fcnt_reg == 5'h0 &&
    !cmd_has_result && disk_exec_done;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
      drq <= 1'b0;
    end else begin
      irq <= irq_next;
      drq <= dma_mode && phase_reg == DCPS_EXEC && fifo_trig && !dack_s && !burst_gap_reg;
    end
  end

  // ****************************************
  // drive polling, stepping, power down
  // ****************************************
  logic [39:0] poll_load;
  logic [39:0] pd_load;
  logic pd_done;
  logic pd_pend_reg;
  logic [7:0] loop_cnt_reg;
  logic [1:0] drv_reg;

  // interval stretches as the rate drops
  function automatic logic [39:0] rate_scale(input logic [39:0] base, input logic [1:0] r);
    case (r)
      DCPS_RATE_1M: rate_scale = base >> 1;
      DCPS_RATE_300K: rate_scale = 40'((base * 5) / 3);
      DCPS_RATE_250K: rate_scale = base << 1;
      default: rate_scale = base;
    endcase
  endfunction

  assign poll_load = rate_scale(40'(POLL_CYC), data_rate);
  // 1 mbps keeps the 500 kbps figure
  assign pd_load = (data_rate == DCPS_RATE_1M) ? 40'(PDOWN_CYC) :
    rate_scale(40'(PDOWN_CYC), data_rate);

  dcps_timer #(.WIDTH(40)) u_poll (.clk_sys(clk_sys), .nrst(nrst),
    .load(phase_reg != DCPS_IDLE), .count(poll_load), .run(1'b1), .done(poll_tick));
  dcps_timer #(.WIDTH(40)) u_pd (.clk_sys(clk_sys), .nrst(nrst),
    .load(!(autopd_en && motor_off_expired) || power_down), .count(pd_load),
    .run(1'b1), .done(pd_done));

  assign loop_done = phase_reg == DCPS_POLL && loop_cnt_reg == 8'(DCPS_POLL_LOOP_CYC - 1);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      loop_cnt_reg <= 8'h00;
      drv_reg <= 2'h0;
      ready_chg_reg <= 4'hf;  // only reset marks the ready lines changed
      step_pulse <= 1'b0;
      step_dir <= 1'b0;
      power_down <= 1'b0;
      pd_pend_reg <= 1'b0;
    end else begin
      loop_cnt_reg <= (phase_reg == DCPS_POLL) ? loop_cnt_reg + 8'h1 : 8'h00;
      step_pulse <= 1'b0;
      if (phase_reg == DCPS_POLL && loop_cnt_reg[3:0] == 4'hf) begin
        drv_reg <= drv_reg + 2'h1;
        // stepping regardless of poll_disable
        if (step_needed[drv_reg]) begin
          step_dir <= step_dir_want[drv_reg];
          step_pulse <= 1'b1;
        end
      end
      if (poll_disable) begin
        ready_chg_reg <= 4'h0;
      end else if (phase_reg == DCPS_RESULT && data_rd && res_idx_reg == 2'h0 &&
                   ready_chg_reg != 4'h0) begin
        ready_chg_reg <= ready_chg_reg & (ready_chg_reg - 4'h1);
      end
      // done may pulse outside polling; held until the next loop
      if (!(autopd_en && motor_off_expired)) begin
        pd_pend_reg <= 1'b0;
      end else if (pd_done) begin
        pd_pend_reg <= 1'b1;
      end else if (phase_reg == DCPS_POLL) begin
        pd_pend_reg <= 1'b0;
      end
      if (pd_pend_reg && autopd_en && motor_off_expired && phase_reg == DCPS_POLL) begin
        power_down <= 1'b1;
      end else if (host_xfer) begin
        power_down <= 1'b0;
      end
    end
  end

  // ****************************************
  // status and data read port
  // ****************************************
  logic [7:0] status_word;
  always_comb begin
    status_word = 8'h00;
    status_word[DCPS_MS_DRV_HI:0] = ready_chg_reg;
    status_word[DCPS_MS_ACTIVE] = active_reg;
    status_word[DCPS_MS_PROG] = phase_reg == DCPS_EXEC && !dma_mode;
    status_word[DCPS_MS_DIR] = phase_reg == DCPS_RESULT ||
      (phase_reg == DCPS_EXEC && cmd_is_read);
    case (phase_reg)
      DCPS_EXEC: status_word[DCPS_MS_HREQ] = dma_mode ? 1'b0 : irq;
      DCPS_POLL: status_word[DCPS_MS_HREQ] = !poll_hold_reg && !active_reg;
      DCPS_PAD: status_word[DCPS_MS_HREQ] = 1'b0;
      default: status_word[DCPS_MS_HREQ] = 1'b1;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else if (addr == DCPS_ADDR_STATUS) begin
      rdata <= status_word;
    end else if (addr == DCPS_ADDR_DATA && phase_reg == DCPS_RESULT) begin
      // result bytes appear only here
      rdata <= (res_idx_reg != 2'h0) ? DCPS_RESULT_STATUS_OK :
        (ready_chg_reg != 4'h0) ? DCPS_RESULT_STATUS_POLL :
        ovr_reg ? DCPS_RESULT_STATUS_OVR : DCPS_RESULT_STATUS_OK;
    end else if (addr == DCPS_ADDR_DATA && phase_reg == DCPS_EXEC) begin
      rdata <= fifo_mem[fhead_reg];
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule

// ### dv/dcps_props.sv
// port checker for the phase sequencer
// assumes one clock domain, bound onto dcps_top
`timescale 1ns/1ps
module dcps_props
  import dcps_pkg::*;
#(
  parameter longint PDOWN_CYC = 200
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // watched ports
  input wire logic [2:0] addr,
  input wire logic rd_n,
  input wire logic dack_n,
  input wire logic [7:0] rdata,
  input wire logic irq,
  input wire logic drq,
  input wire logic dma_mode,
  input wire logic autopd_en,
  input wire logic motor_off_expired,
  input wire logic cmd_has_result,
  input wire logic cmd_is_read,
  input wire logic [3:0] step_needed,
  input wire logic disk_exec_done,
  input wire logic step_pulse,
  input wire logic power_down
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  longint wait_cnt;
  // cycles spent with power-down armed
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wait_cnt <= 0;
    end else if (!(autopd_en && motor_off_expired)) begin
      wait_cnt <= 0;
    end else begin
      wait_cnt <= wait_cnt + 1;
    end
  end
  sequence s_irq_data_rd;
    irq && $fell(rd_n) && addr == DCPS_ADDR_DATA && dack_n;
  endsequence
  a_irq_rd_clear: assert property (s_irq_data_rd |-> ##[1:8] !irq)
    else $error("irq held after data read");
  a_exec_end_irq: assert property (
    disk_exec_done && cmd_has_result && !cmd_is_read |-> ##[1:4] irq)
    else $error("no irq at end of execution");
  a_unmapped_zero: assert property (
    dack_n && !(addr inside {3'h4, 3'h5}) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_step_one_cycle: assert property (step_pulse |=> !step_pulse)
    else $error("step pulse too long");
  a_step_has_cause: assert property (step_pulse |-> step_needed != 4'h0)
    else $error("step without need");
  a_drq_dma_only: assert property (drq |-> dma_mode)
    else $error("drq in non-dma mode");
  a_pdown_cause: assert property (
    $rose(power_down) |-> autopd_en && motor_off_expired)
    else $error("power down without cause");
  a_pdown_delay: assert property ($rose(power_down) |-> wait_cnt >= PDOWN_CYC)
    else $error("power down too early");
endmodule
bind dcps_top dcps_props #(.PDOWN_CYC(PDOWN_CYC)) u_props (.clk_sys, .nrst, .addr, .rd_n,
  .dack_n, .rdata, .irq, .drq, .dma_mode, .autopd_en, .motor_off_expired, .cmd_has_result,
  .cmd_is_read, .step_needed, .disk_exec_done, .step_pulse, .power_down);

// ### dv/dcps_host.sv
// host bus model: strobed register reads and writes
// assumes the bench calls its tasks; pins move on falling edges
`timescale 1ns/1ps
module dcps_host
  import dcps_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // bus pins
  output logic [2:0] addr,
  output logic rd_n,
  output logic wr_n,
  output logic dack_n,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  initial begin
    addr = 3'h0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    dack_n = 1'b1;
    wdata = 8'h00;
  end
  // read data sampled before the strobe is taken, since a take pops
  task automatic xfer(input logic wr, input logic [2:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(negedge clk_sys);
    addr = a;
    wdata = wr ? d : ~wdata;
    rd_n = wr;
    wr_n = !wr;
    repeat (2) @(negedge clk_sys);
    q = rdata;
    repeat (4) @(negedge clk_sys);
    rd_n = 1'b1;
    wr_n = 1'b1;
    wdata = ~wdata;
    repeat (6) @(negedge clk_sys);
  endtask
  task automatic get_result(output logic [7:0] q);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 40 && s[7:6] !== 2'b11; i++) begin
      xfer(1'b0, DCPS_ADDR_STATUS, 8'h00, s);
    end
    xfer(1'b0, DCPS_ADDR_DATA, 8'h00, q);
  endtask
endmodule

// ### dv/dcps_top_test.sv
// self-checking bench for the phase sequencer
// assumes dcps_host as bus partner and the bound checker
`timescale 1ns/1ps
module dcps_top_test;
  import dcps_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] addr;
  logic rd_n, wr_n, dack_n, irq, drq, disk_wstb, step_pulse, step_dir, power_down;
  logic [7:0] wdata, rdata, disk_wbyte;
  logic [7:0] disk_rbyte = 8'h5a;
  logic [1:0] data_rate = DCPS_RATE_500K;
  logic autopd_en = 1'b0, motor_off_expired = 1'b0, cmd_last_byte = 1'b1;
  logic cmd_has_result = 1'b1, cmd_is_read = 1'b0;
  logic dma_mode = 1'b0, poll_disable = 1'b1;
  logic [2:0] result_count = 3'h3;
  logic [3:0] step_needed = 4'h0, step_dir_want = 4'h0;
  logic disk_byte_ready = 1'b0, disk_sector_end = 1'b0;
  logic disk_exec_done = 1'b0, disk_service_late = 1'b0;
  int num_errors = 0;
  int samples_checked = 0;
  // polling disabled from reset on, so no ready-change interrupts
  dcps_top #(.POLL_CYC(20000), .PDOWN_CYC(200)) dut (.clk_sys, .nrst, .addr, .rd_n, .wr_n,
    .dack_n, .wdata, .rdata, .irq, .drq, .dma_mode, .fifo_on(1'b0), .burst_on(1'b0),
    .fifo_thresh(4'h0), .data_rate, .poll_disable, .autopd_en, .motor_off_expired,
    .cmd_last_byte, .cmd_has_result, .cmd_is_read, .result_count, .step_needed,
    .step_dir_want, .disk_byte_ready, .disk_sector_end, .disk_exec_done, .disk_service_late,
    .disk_rbyte, .disk_wbyte, .disk_wstb, .step_pulse, .step_dir, .power_down);
  dcps_host h (.clk_sys, .addr, .rd_n, .wr_n, .dack_n, .wdata, .rdata);
  always #2 clk_sys = ~clk_sys;
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("errors=%0d checks=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk_sys);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
  endtask
  task automatic wait_sig(ref logic s, input int lim);
    for (int i = 0; i < lim && s !== 1'b1; i++) @(negedge clk_sys);
    check8({7'h00, s}, 8'h01);
  endtask
  task automatic t_idle;
    logic [7:0] q;
    h.xfer(1'b0, DCPS_ADDR_STATUS, 8'h00, q);
    check8(q, 8'h80);
    h.xfer(1'b0, 3'h3, 8'h00, q);
    check8(q, 8'h00);
    h.xfer(1'b0, DCPS_ADDR_DATA, 8'h00, q);
    check8(q, 8'h00);
  endtask
  task automatic t_result;
    logic [7:0] q;
    h.xfer(1'b1, DCPS_ADDR_DATA, 8'h46, q);
    h.xfer(1'b0, DCPS_ADDR_STATUS, 8'h00, q);
    check8({7'h00, q[DCPS_MS_ACTIVE]}, 8'h01);
    h.xfer(1'b1, DCPS_ADDR_DATA, 8'ha5, q);
    pulse(disk_byte_ready);
    check8(disk_wbyte, 8'ha5);
    check8({7'h00, disk_wstb}, 8'h01);
    pulse(disk_exec_done);
    wait_sig(irq, 20);
    h.xfer(1'b0, DCPS_ADDR_STATUS, 8'h00, q);
    check8({4'h0, q[7:4]}, 8'h0d);
    for (int i = 0; i < 3; i++) begin
      h.get_result(q);
      check8(q, DCPS_RESULT_STATUS_OK);
      check8({7'h00, irq}, 8'h00);
    end
    h.xfer(1'b0, DCPS_ADDR_STATUS, 8'h00, q);
    check8(q, 8'h80);
  endtask
  task automatic t_overrun;
    logic [7:0] q;
    cmd_is_read = 1'b1;
    result_count = 3'h1;
    h.xfer(1'b1, DCPS_ADDR_DATA, 8'h46, q);
    pulse(disk_byte_ready);
    wait_sig(irq, 20);
    h.xfer(1'b0, DCPS_ADDR_STATUS, 8'h00, q);
    check8({4'h0, q[7:4]}, 8'h0f);
    h.xfer(1'b0, DCPS_ADDR_DATA, 8'h00, q);
    check8(q, 8'h5a);
    check8({7'h00, irq}, 8'h00);
    pulse(disk_byte_ready);
    pulse(disk_service_late);
    pulse(disk_sector_end);
    pulse(disk_exec_done);
    h.xfer(1'b0, DCPS_ADDR_DATA, 8'h00, q);
    check8(q, 8'h5a);
    wait_sig(irq, 20);
    h.get_result(q);
    check8(q, DCPS_RESULT_STATUS_OVR);
  endtask
  task automatic t_noresult;
    logic [7:0] q;
    cmd_has_result = 1'b0;
    cmd_is_read = 1'b0;
    h.xfer(1'b1, DCPS_ADDR_DATA, 8'h07, q);
    h.xfer(1'b0, DCPS_ADDR_STATUS, 8'h00, q);
    check8({7'h00, q[DCPS_MS_ACTIVE]}, 8'h00);
    pulse(disk_exec_done);
    h.xfer(1'b0, DCPS_ADDR_STATUS, 8'h00, q);
    check8(q, 8'h80);
  endtask
  task automatic t_step;
    @(negedge clk_sys);
    step_needed = 4'h2;
    step_dir_want = 4'h2;
    wait_sig(step_pulse, 25000);
    check8({7'h00, step_dir}, 8'h01);
    @(negedge clk_sys);
    step_needed = 4'h0;
  endtask
  task automatic t_pdown;
    @(negedge clk_sys);
    data_rate = DCPS_RATE_1M;
    autopd_en = 1'b1;
    motor_off_expired = 1'b1;
    wait_sig(power_down, 45000);
  endtask
  initial begin
    repeat (6) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (80) @(negedge clk_sys);
    t_idle();
    t_result();
    t_overrun();
    t_noresult();
    t_step();
    t_pdown();
    tally_and_finish();
  end
  // covers both polling waits plus the bus scenarios
  initial begin
    repeat (90000) @(posedge clk_sys);
    num_errors++;
    tally_and_finish();
  end
endmodule
